// File: adcp_pkg.sv
// shared constants for the converter readout and status port
package adcp_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PWRUP_TIME_NS = 10000;
    localparam int CONV_TIME_NS  = 5000;
    localparam int PWRUP_CYC     = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int TMR_W         = 12;

    // ------------------------------------------------------------
    // result layout
    // ------------------------------------------------------------
    localparam int RES_W   = 14;
    localparam int WORD_W  = 16;
    localparam int BYTE_W  = 8;
    localparam int PAD_W   = WORD_W - RES_W;

    // ------------------------------------------------------------
    // apb register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam int CTRL_START_BIT   = 0;
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_READY_BIT   = 1;
    localparam int STAT_BIPOLAR_BIT = 2;
endpackage : adcp_pkg

// File: adcp_timer.sv
// down-counting interval timer with busy level and last-cycle flag
`timescale 1ns/100ps
`default_nettype none
module adcp_timer #(
    parameter int                       W          = 12,
    parameter logic [W-1:0]             RESET_LOAD = '0
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // control
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    // status
    output logic              busy,
    output logic              last
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (start && count == '0) begin
            next_count = load;
        end else if (count != '0) begin
            next_count = count - W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= RESET_LOAD;
        end else begin
            count <= next_count;
        end
    end

    assign busy = (count != '0);
    assign last = (count == W'(1));
endmodule : adcp_timer
`default_nettype wire

// File: adcp_port.sv
// readout and status port of a 14-bit sampling converter, apb side view
//
// Summary of operation
// - data bus driven only while select and read drive are both low.
// - conv_done high marks a finished conversion with a valid result.
// - upper_byte_sel low gives top eight bits, high gives six plus zeros.
// - 14-bit result left justified in 16 bits, two low bits zero.
// - offset_pin low gives straight binary, high gives twos complement.
// - no conversion starts during the 10 us power-up interval.
// - synchronous mode drives conv_done only with select and done enable low.
// - asynchronous mode pulls conv_done low while converting with done enable low, needs pull-up.
// - sync starts on select and trigger low, async on trigger fall.
// - conv_done high while idle, low for the whole conversion.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module adcp_port (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // host control pins
    input  wire logic        device_select_n,
    input  wire logic        read_drive_n,
    input  wire logic        upper_byte_sel,
    input  wire logic        done_drive_en_n,
    input  wire logic        convert_trigger_n,
    input  wire logic        timing_mode_sel,
    input  wire logic        offset_pin,
    // sample word from the converter core, straight binary
    input  wire logic [13:0] conv_sample,
    // data bus pins
    output logic [7:0]       out_bus_o,
    output logic             out_bus_oe,
    // status pin
    output logic             conv_done_o,
    output logic             conv_done_oe
);
    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic logic [adcp_pkg::WORD_W-1:0] code_word(
        input logic [adcp_pkg::RES_W-1:0] raw,
        input logic                       bipolar
    );
        logic [adcp_pkg::RES_W-1:0] c;
        c = raw;
        c[adcp_pkg::RES_W-1] = raw[adcp_pkg::RES_W-1] ^ bipolar;
        return {c, {adcp_pkg::PAD_W{1'b0}}};
    endfunction : code_word

    function automatic logic apb_hit(input logic [7:0] a);
        return (a == adcp_pkg::ADDR_CTRL) || (a == adcp_pkg::ADDR_STATUS)
            || (a == adcp_pkg::ADDR_RESULT);
    endfunction : apb_hit

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    logic pwr_busy;
    logic conv_busy;
    logic conv_end;
    logic start_conv;

    adcp_timer #(
        .W          (adcp_pkg::TMR_W),
        .RESET_LOAD (adcp_pkg::TMR_W'(adcp_pkg::PWRUP_CYC))
    ) u_pwr (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (1'b0),
        .load    ('0),
        .busy    (pwr_busy),
        .last    ()
    );

    adcp_timer #(
        .W          (adcp_pkg::TMR_W),
        .RESET_LOAD ('0)
    ) u_conv (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (start_conv),
        .load    (adcp_pkg::TMR_W'(adcp_pkg::CONV_CYC)),
        .busy    (conv_busy),
        .last    (conv_end)
    );

    // ------------------------------------------------------------
    // conversion start and result capture
    // ------------------------------------------------------------
    logic                         trig_prev;
    logic                         soft_start;
    logic [adcp_pkg::WORD_W-1:0]  result;
    logic                         next_trig_prev;
    logic                         next_soft_start;
    logic [adcp_pkg::WORD_W-1:0]  next_result;
    logic                         pin_start;
    logic                         apb_wr;

    assign apb_wr = psel && penable && pready && pwrite;

    always_comb begin
        // a held trigger in sync mode restarts at once: continuous mode
        if (timing_mode_sel) begin
            pin_start = !device_select_n && !convert_trigger_n;
        end else begin
            pin_start = trig_prev && !convert_trigger_n;
        end
        // starts are ignored while the internal logic is still settling
        start_conv = !pwr_busy && !conv_busy && (pin_start || soft_start);
        next_trig_prev  = convert_trigger_n;
        next_soft_start = apb_wr && (paddr == adcp_pkg::ADDR_CTRL)
                          && pwdata[adcp_pkg::CTRL_START_BIT];
        next_result = result;
        if (conv_end) begin
            next_result = code_word(conv_sample, offset_pin);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev  <= 1'b1;
            soft_start <= 1'b0;
            result     <= '0;
        end else begin
            trig_prev  <= next_trig_prev;
            soft_start <= next_soft_start;
            result     <= next_result;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    logic [7:0] next_out_bus_o;
    logic       next_out_bus_oe;
    logic       next_conv_done_o;
    logic       next_conv_done_oe;

    always_comb begin
        next_out_bus_oe = !device_select_n && !read_drive_n;
        if (upper_byte_sel) begin
            next_out_bus_o = result[adcp_pkg::BYTE_W-1:0];
        end else begin
            next_out_bus_o = result[adcp_pkg::WORD_W-1:adcp_pkg::BYTE_W];
        end
        if (timing_mode_sel) begin
            next_conv_done_oe = !device_select_n && !done_drive_en_n;
            next_conv_done_o  = !conv_busy;
        end else begin
            // open drain: only ever drives low, the board pull-up makes high
            next_conv_done_oe = conv_busy && !done_drive_en_n;
            next_conv_done_o  = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_bus_o    <= '0;
            out_bus_oe   <= 1'b0;
            conv_done_o  <= 1'b0;
            conv_done_oe <= 1'b0;
        end else begin
            out_bus_o    <= next_out_bus_o;
            out_bus_oe   <= next_out_bus_oe;
            conv_done_o  <= next_conv_done_o;
            conv_done_oe <= next_conv_done_oe;
        end
    end

    // ------------------------------------------------------------
    // apb slave: one wait-free access phase, answer prepared in setup
    // ------------------------------------------------------------
    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;

    always_comb begin
        next_pready  = psel && !penable;
        next_prdata  = '0;
        next_pslverr = psel && !penable && !apb_hit(paddr);
        if (psel && !penable && !pwrite) begin
            case (paddr)
                adcp_pkg::ADDR_STATUS: begin
                    next_prdata[adcp_pkg::STAT_BUSY_BIT]    = conv_busy;
                    next_prdata[adcp_pkg::STAT_READY_BIT]   = !pwr_busy;
                    next_prdata[adcp_pkg::STAT_BIPOLAR_BIT] = offset_pin;
                end
                adcp_pkg::ADDR_RESULT: begin
                    next_prdata[adcp_pkg::WORD_W-1:0] = result;
                end
                default: begin
                    next_prdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= next_pready;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_bus_off;
        (device_select_n || read_drive_n) |=> !out_bus_oe;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("data bus driven while deselected");

    property p_high_byte;
        (!device_select_n && !read_drive_n && !upper_byte_sel)
            |=> out_bus_oe && out_bus_o == $past(result[15:8]);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("wrong high byte");

    property p_low_pad;
        (!device_select_n && !read_drive_n && upper_byte_sel) |=> out_bus_o[1:0] == 2'h0;
    endproperty
    a_low_pad: assert property (p_low_pad) else $error("low byte padding not zero");

    property p_coding;
        conv_end |=> result[15] == $past(conv_sample[13] ^ offset_pin)
                     && result[14:2] == $past(conv_sample[12:0]);
    endproperty
    a_coding: assert property (p_coding) else $error("result coding wrong");

    property p_no_early;
        pwr_busy |=> !$rose(conv_busy);
    endproperty
    a_no_early: assert property (p_no_early) else $error("start during power-up");

    property p_sync_float;
        (timing_mode_sel && (device_select_n || done_drive_en_n)) |=> !conv_done_oe;
    endproperty
    a_sync_float: assert property (p_sync_float) else $error("status driven in sync float");

    property p_async_pull;
        (!timing_mode_sel && !done_drive_en_n && conv_busy) |=> conv_done_oe && !conv_done_o;
    endproperty
    a_async_pull: assert property (p_async_pull) else $error("status not pulled low");

    property p_async_start;
        (!timing_mode_sel && !pwr_busy && !conv_busy && $fell(convert_trigger_n)) |=> conv_busy;
    endproperty
    a_async_start: assert property (p_async_start) else $error("trigger fall missed");

    property p_busy_hold;
        $rose(conv_busy) |-> conv_busy [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("conversion cut short");

    property p_done_valid;
        (conv_end && timing_mode_sel) |=> !conv_busy ##1 (conv_done_o && $stable(result));
    endproperty
    a_done_valid: assert property (p_done_valid) else $error("done without result");

    property p_hold_result;
        !conv_end |=> $stable(result);
    endproperty
    a_hold_result: assert property (p_hold_result) else $error("result changed early");

    property p_c_conv;
        $rose(conv_busy) ##[1:1000] conv_end;
    endproperty
    c_conv: cover property (p_c_conv);

    property p_c_two_bytes;
        (out_bus_oe && !upper_byte_sel) ##[1:20] (out_bus_oe && upper_byte_sel);
    endproperty
    c_two_bytes: cover property (p_c_two_bytes);

    property p_c_async;
        !timing_mode_sel && conv_done_oe;
    endproperty
    c_async: cover property (p_c_async);
endmodule : adcp_port
`default_nettype wire

// File: adcp_host_model.sv
// host bus model: drives the converter pins and resolves its three-state lines
`timescale 1ns/100ps
`default_nettype none
module adcp_host_model (
    // clock
    input  wire logic       pclk,
    // pins toward the port
    output logic            device_select_n,
    output logic            read_drive_n,
    output logic            upper_byte_sel,
    output logic            done_drive_en_n,
    output logic            convert_trigger_n,
    // three-state lines from the port
    input  wire logic [7:0] out_bus_o,
    input  wire logic       out_bus_oe,
    input  wire logic       conv_done_o,
    input  wire logic       conv_done_oe,
    // resolved line levels
    output logic [7:0]      out_bus,
    output logic            conv_done
);
    logic [7:0] last_bus;

    initial begin
        {device_select_n, read_drive_n, upper_byte_sel} = 3'h7;
        {done_drive_en_n, convert_trigger_n} = 2'h3;
        last_bus = 8'h00;
    end

    // a floating bus shows the inverse of its last level, so stale data never matches
    always @(posedge pclk) if (out_bus_oe) last_bus <= out_bus_o;
    assign out_bus   = out_bus_oe ? out_bus_o : ~last_bus;
    assign conv_done = conv_done_oe ? conv_done_o : 1'b1;

    // order: select, read drive, byte select, done enable, trigger
    task automatic pins(input logic [4:0] v);
        @(posedge pclk);
        {device_select_n, read_drive_n, upper_byte_sel, done_drive_en_n, convert_trigger_n} <= v;
    endtask : pins

    task automatic read_byte(input logic upper, output logic [7:0] b);
        pins({2'b00, upper, 2'b11});
        repeat (2) @(posedge pclk);
        #1 b = out_bus;
        pins(5'h1F);
    endtask : read_byte

    task automatic read_word(output logic [15:0] w);
        read_byte(1'b0, w[15:8]);
        read_byte(1'b1, w[7:0]);
    endtask : read_word
endmodule : adcp_host_model
`default_nettype wire

// File: testbench.sv
// self-checking bench for the converter readout and status port
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, out_bus_o, out_bus;
    logic [31:0] pwdata, prdata, rd;
    logic        device_select_n, read_drive_n, upper_byte_sel, done_drive_en_n;
    logic        convert_trigger_n, timing_mode_sel, offset_pin;
    logic        out_bus_oe, conv_done_o, conv_done_oe, conv_done;
    logic [13:0] conv_sample;
    logic [15:0] w, expw;
    int          fail_count, n_checks;
    int          cyc = 0;
    localparam logic [13:0] SAMP [4] = '{14'h2A5B, 14'h1FFF, 14'h3C01, 14'h0002};

    adcp_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .device_select_n, .read_drive_n, .upper_byte_sel,
        .done_drive_en_n, .convert_trigger_n, .timing_mode_sel, .offset_pin,
        .conv_sample, .out_bus_o, .out_bus_oe, .conv_done_o, .conv_done_oe);

    adcp_host_model host (.pclk, .device_select_n, .read_drive_n, .upper_byte_sel,
        .done_drive_en_n, .convert_trigger_n, .out_bus_o, .out_bus_oe, .conv_done_o,
        .conv_done_oe, .out_bus, .conv_done);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // a hung wait still reaches the verdict
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk_bit(input logic a, input logic e);
        n_checks++;
        if (a !== e) begin
            fail_count++;
            $display("Error %0t: bit %b want %b", $time, a, e);
        end
    endtask : chk_bit

    task automatic chk_word(input logic [31:0] a, input logic [31:0] e);
        n_checks++;
        if (a !== e) begin
            fail_count++;
            $display("Error %0t: word %h want %h", $time, a, e);
        end
    endtask : chk_word

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the bench timeout ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // start one conversion and follow the status pin until it reports done
    task automatic convert(input logic sync_m);
        int n;
        host.pins({~sync_m, 4'b1110});
        host.pins({~sync_m, 4'b1101});
        repeat (3) @(posedge pclk);
        #1 chk_bit(conv_done, 1'b0);
        chk_bit(conv_done_oe, 1'b1);
        n = 0;
        while (conv_done !== 1'b1 && n < 600) begin
            @(posedge pclk);
            n++;
        end
        chk_bit(n > 480 && n < 520, 1'b1);
        #1 chk_bit(conv_done_oe, sync_m);
        host.pins(5'h1F);
        repeat (2) @(posedge pclk);
        #1 chk_bit(conv_done_oe, 1'b0);
        chk_bit(out_bus_oe, 1'b0);
    endtask : convert

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, timing_mode_sel, offset_pin} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        conv_sample = 14'h0000;
        fail_count = 0;
        n_checks = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        host.pins(5'h1E);
        host.pins(5'h1F);
        apb(1'b0, adcp_pkg::ADDR_STATUS, 32'h0);
        chk_word(rd, 32'h0);
        repeat (1000) @(posedge pclk);
        apb(1'b0, adcp_pkg::ADDR_STATUS, 32'h0);
        chk_word(rd, 32'h2);
        for (int i = 0; i < 4; i++) begin
            timing_mode_sel <= i[1];
            offset_pin <= i[0];
            conv_sample <= SAMP[i];
            convert(i[1]);
            expw = {SAMP[i][13] ^ i[0], SAMP[i][12:0], 2'b00};
            host.read_word(w);
            chk_word(w, expw);
            conv_sample <= ~SAMP[i];
            host.read_word(w);
            chk_word(w, expw);
            apb(1'b0, adcp_pkg::ADDR_RESULT, 32'h0);
            chk_word(rd, {16'h0000, expw});
        end
        apb(1'b1, adcp_pkg::ADDR_CTRL, 32'h1);
        apb(1'b0, adcp_pkg::ADDR_STATUS, 32'h0);
        chk_word(rd, 32'h7);
        apb(1'b0, 8'h0C, 32'h0);
        chk_bit(err, 1'b1);
        chk_word(rd, 32'h0);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
